// ---- hdl/acc_exec.sv ----
// execution of soft interrupt and six accumulator loads, behind an apb slave
// assumes: apb master on mclk; software supplies instruction words and operand
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acc_exec #(
  parameter int unsigned stack_depth = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware stack push
  output logic push_valid,
  output logic [15:0] push_data,
  // status
  output logic busy
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_wait = 3'b010,
    st_done = 3'b100
  } state_e;
  state_e state_q;

  logic [31:0] acc_q;
  logic [15:0] ar_q [8];
  logic [2:0] arp_q;
  logic [8:0] dp_q;
  logic [15:0] temporary_operand_register_q;
  logic sxm_q;
  logic global_interrupt_mask_bit_q;
  logic [15:0] pc_q;
  logic [15:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] iw1_q;
  logic [15:0] iw2_q;
  logic [7:0] rpt_q;
  logic [3:0] dwait_q;
  logic [3:0] pwait_q;
  logic ext_op_q;
  logic ext_code_q;
  logic same_single_access_ram_q;
  logic [acc_exec_pkg::cnt_w-1:0] cnt_q;
  logic [acc_exec_pkg::cnt_w-1:0] cycles_q;

  wire logic wr_acc = psel && penable && pwrite;
  wire logic rd_acc = psel && penable && !pwrite;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic is_load_acc_shifted_instr_sh = iw1_q[15:12] == acc_exec_pkg::op_load_acc_shifted_instr_sh;
  wire logic is_load_acc_shifted_instr_16 = iw1_q[15:8] == acc_exec_pkg::op_load_acc_shifted_instr_16;
  wire logic is_load_acc_low_instr = iw1_q[15:8] == acc_exec_pkg::op_load_acc_low_instr;
  wire logic is_load_acc_temporary_operand_register_shift_instr = iw1_q[15:8] == acc_exec_pkg::op_load_acc_temporary_operand_register_shift_instr;
  wire logic is_load_acc_low_instr_k = iw1_q[15:8] == acc_exec_pkg::op_load_acc_low_instr_k;
  wire logic is_load_acc_shifted_instr_lk = iw1_q[15:4] == acc_exec_pkg::op_load_acc_shifted_instr_lk;
  wire logic is_software_interrupt_instr = iw1_q[15:5] == acc_exec_pkg::op_software_interrupt_instr;
  wire logic is_mem = is_load_acc_shifted_instr_sh || is_load_acc_shifted_instr_16 || is_load_acc_low_instr || is_load_acc_temporary_operand_register_shift_instr;
  wire logic indirect = iw1_q[7];
  wire logic [2:0] aux_update_code = iw1_q[6:4];
  wire logic nar_en = iw1_q[3];
  wire logic [2:0] next_aux_register_number = iw1_q[2:0];

  // direct address: page on top, offset below
  wire logic [15:0] dir_addr = {dp_q, iw1_q[6:0]};

  logic [15:0] ar_next;
  aux_update u_aux (
    .ar_cur(ar_q[arp_q]),
    .ar_idx(ar_q[0]),
    .aux_update_code(aux_update_code),
    .ar_new(ar_next)
  );

  // shift amount and operand selection
  logic [4:0] amt;
  logic [15:0] opnd;
  logic sext;
  logic [31:0] shifted;
  always_comb begin
    amt = 5'h00;
    opnd = data_q;
    sext = sxm_q;
    if (is_load_acc_shifted_instr_sh) begin
      amt = {1'b0, iw1_q[11:8]};
    end else if (is_load_acc_shifted_instr_16) begin
      amt = 5'(acc_exec_pkg::shift16_amt);
    end else if (is_load_acc_temporary_operand_register_shift_instr) begin
      amt = {1'b0, temporary_operand_register_q[3:0]};
    end else if (is_load_acc_shifted_instr_lk) begin
      amt = {1'b0, iw1_q[3:0]};
      opnd = iw2_q;  // second word carries the constant
    end
  end

  acc_shifter u_shift (
    .operand(opnd),
    .amount(amt),
    .sign_ext(sext),
    .result(shifted)
  );

  // cycle count by placement; n=rpt+1
  function automatic logic [7:0] cycle_count(input logic mem_ld, input logic long_k, input logic short_k,
                                             input logic soft_int, input logic [7:0] n, input logic [3:0] d,
                                             input logic [3:0] p, input logic ext_op, input logic ext_code,
                                             input logic same_blk);
    logic [7:0] c;
    c = 8'h01;
    if (soft_int) begin
      c = 8'(acc_exec_pkg::software_interrupt_instr_cycles) + (ext_code ? 8'(acc_exec_pkg::software_interrupt_instr_pwait) * {4'h0, p} : 8'h00);
    end else if (long_k) begin
      c = 8'h02 + (ext_code ? {3'h0, p, 1'b0} : 8'h00);
    end else if (short_k) begin
      c = 8'h01 + (ext_code ? {4'h0, p} : 8'h00);
    end else if (mem_ld) begin
      c = n + (ext_op ? 8'(n * {4'h0, d}) : 8'h00);
      if (ext_op && ext_code) begin
        c = c + 8'h01 + {4'h0, p};
      end else if (ext_code) begin
        c = c + {4'h0, p};
      end else if (same_blk && !ext_op) begin
        c = c + 8'h01;
      end
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // execution sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_idle;
      cnt_q <= '0;
      cycles_q <= '0;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (wr_acc && paddr == acc_exec_pkg::reg_instr) begin
            state_q <= st_wait;
            cnt_q <= 8'h01;
          end
        end
        st_wait: begin
          if (cnt_q == cycle_count(is_mem, is_load_acc_shifted_instr_lk, is_load_acc_low_instr_k, is_software_interrupt_instr, rpt_q + 8'h01, dwait_q, pwait_q,
                                   ext_op_q, ext_code_q, same_single_access_ram_q)) begin
            state_q <= st_done;
            cycles_q <= cnt_q;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        st_done: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // ------------------------------------------------------------
  // architectural state update at completion
  // ------------------------------------------------------------
  wire logic done = state_q == st_done;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      arp_q <= '0;
      global_interrupt_mask_bit_q <= 1'b1;
      pc_q <= '0;
      push_valid <= 1'b0;
      push_data <= '0;
      addr_q <= '0;
      for (int i = 0; i < 8; i++) begin
        ar_q[i] <= '0;
      end
    end else begin
      push_valid <= 1'b0;
      if (wr_acc && paddr >= acc_exec_pkg::reg_ar_base && paddr < acc_exec_pkg::reg_acc && !busy) begin
        ar_q[paddr[4:2] - 3'h4] <= pwdata[15:0];
      end
      if (wr_acc && paddr == acc_exec_pkg::reg_ptr && !busy) begin
        arp_q <= pwdata[11:9];
      end
      if (wr_acc && paddr == acc_exec_pkg::reg_pc && !busy) begin
        pc_q <= pwdata[15:0];
      end
      if (done) begin
        if (is_software_interrupt_instr) begin
          // no mask is consulted before taking it
          push_valid <= 1'b1;
          push_data <= pc_q + 16'h0001;
          pc_q <= acc_exec_pkg::vec_base + 16'(iw1_q[4:0]) * acc_exec_pkg::vec_step;
          global_interrupt_mask_bit_q <= 1'b1;
        end else begin
          pc_q <= pc_q + (is_load_acc_shifted_instr_lk ? 16'h0002 : 16'h0001);
          if (is_load_acc_low_instr) begin
            acc_q <= {16'h0000, data_q};
          end else if (is_load_acc_low_instr_k) begin
            acc_q <= {24'h000000, iw1_q[7:0]};
          end else if (is_mem || is_load_acc_shifted_instr_lk) begin
            acc_q <= shifted;
          end
          if (is_mem) begin
            addr_q <= indirect ? ar_q[arp_q] : dir_addr;
            if (indirect) begin
              ar_q[arp_q] <= ar_next;
              if (nar_en) begin
                arp_q <= next_aux_register_number;
              end
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // software-set configuration
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iw1_q <= '0;
      iw2_q <= '0;
      sxm_q <= 1'b1;
      rpt_q <= '0;
      dwait_q <= '0;
      pwait_q <= '0;
      ext_op_q <= 1'b0;
      ext_code_q <= 1'b0;
      same_single_access_ram_q <= 1'b0;
      dp_q <= '0;
      temporary_operand_register_q <= '0;
      data_q <= '0;
    end else if (wr_acc && !busy) begin
      unique case (paddr)
        acc_exec_pkg::reg_instr: begin
          iw1_q <= pwdata[15:0];
          iw2_q <= pwdata[31:16];
        end
        acc_exec_pkg::reg_ctrl: begin
          ext_op_q <= pwdata[0];
          ext_code_q <= pwdata[1];
          same_single_access_ram_q <= pwdata[2];
          sxm_q <= pwdata[3];
          dwait_q <= pwdata[7:4];
          pwait_q <= pwdata[11:8];
          rpt_q <= pwdata[23:16];
        end
        acc_exec_pkg::reg_ptr: begin
          dp_q <= pwdata[8:0];
          temporary_operand_register_q <= pwdata[31:16];
        end
        acc_exec_pkg::reg_data: data_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb read and response
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= acc_exec_pkg::reg_data;
  endfunction

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= (state_q != st_idle) || (wr_acc && paddr == acc_exec_pkg::reg_instr && !pready);
      pready <= psel && !pready && (penable || !penable);
      pslverr <= psel && !pready && !mapped(paddr);
      prdata <= '0;
      if (psel && !pwrite) begin
        unique case (paddr)
          acc_exec_pkg::reg_instr: prdata <= {iw2_q, iw1_q};
          acc_exec_pkg::reg_ctrl: prdata <= {8'h00, rpt_q, 4'h0, pwait_q, dwait_q, sxm_q, same_single_access_ram_q, ext_code_q,
                                              ext_op_q};
          acc_exec_pkg::reg_ptr: prdata <= {temporary_operand_register_q, 4'h0, arp_q, dp_q};
          acc_exec_pkg::reg_acc: prdata <= acc_q;
          acc_exec_pkg::reg_status: prdata <= {16'h0000, cycles_q, 6'h00, global_interrupt_mask_bit_q, state_q != st_idle};
          acc_exec_pkg::reg_pc: prdata <= {addr_q, pc_q};
          acc_exec_pkg::reg_data: prdata <= {16'h0000, data_q};
          default: begin
            if (paddr >= acc_exec_pkg::reg_ar_base && paddr < acc_exec_pkg::reg_acc) begin
              prdata <= {16'h0000, ar_q[paddr[4:2] - 3'h4]};
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_software_interrupt_instr_push: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_software_interrupt_instr |=> push_valid && push_data == $past(pc_q) + 16'h0001)
    else $error("soft interrupt did not push pc+1");
  chk_software_interrupt_instr_mask: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_software_interrupt_instr |=> global_interrupt_mask_bit_q)
    else $error("soft interrupt left mask clear");
  chk_low_upper: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_load_acc_low_instr |=> acc_q[31:16] == 16'h0000)
    else $error("low load left upper half set");
  chk_short_k: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_load_acc_low_instr_k |=> acc_q == {24'h000000, $past(iw1_q[7:0])})
    else $error("short constant not zero-extended");
  chk_shift16: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_load_acc_shifted_instr_16 |=> acc_q[15:0] == 16'h0000)
    else $error("shift-16 load left low half set");
  chk_nar_load: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_mem && indirect && nar_en |=> arp_q == $past(next_aux_register_number))
    else $error("pointer not loaded from next aux number");
  chk_int_cycles: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_mem && !ext_op_q && !ext_code_q && !same_single_access_ram_q && rpt_q == 8'h00 |-> cycles_q == 8'h01)
    else $error("internal single load not one cycle");
  chk_long_pc: assert property (@(posedge mclk) disable iff (!nrst)
    done && is_load_acc_shifted_instr_lk |=> pc_q == $past(pc_q) + 16'h0002)
    else $error("long form did not skip two words");
endmodule
`default_nettype wire

// ---- hdl/acc_exec_pkg.sv ----
// constants for the accumulator-load and software-interrupt execution block
// assumes nothing of its surroundings; shared by acc_exec and aux_update
package acc_exec_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned word_w = 16;
  localparam int unsigned acc_w = 32;
  localparam int unsigned dp_w = 9;
  localparam int unsigned dma_w = 7;
  localparam int unsigned arp_w = 3;
  localparam int unsigned shift_w = 4;
  localparam int unsigned vec_w = 5;
  localparam int unsigned cnt_w = 8;
  // ------------------------------------------------------------
  // opcode fields
  // ------------------------------------------------------------
  localparam logic [3:0] op_load_acc_shifted_instr_sh = 4'h1;   // 0001 ssss
  localparam logic [7:0] op_load_acc_shifted_instr_16 = 8'h6a;
  localparam logic [7:0] op_load_acc_low_instr = 8'h69;
  localparam logic [7:0] op_load_acc_temporary_operand_register_shift_instr = 8'h6b;
  localparam logic [7:0] op_load_acc_low_instr_k = 8'hb9;
  localparam logic [11:0] op_load_acc_shifted_instr_lk = 12'hbf8;
  localparam logic [10:0] op_software_interrupt_instr = 11'h5f3;   // 101111100 11 kkkkk
  localparam logic [3:0] shift16 = 4'h0;
  localparam int unsigned shift16_amt = 16;
  // ------------------------------------------------------------
  // aux update codes
  // ------------------------------------------------------------
  localparam logic [2:0] aru_none = 3'h0;
  localparam logic [2:0] aru_dec = 3'h1;
  localparam logic [2:0] aru_inc = 3'h2;
  localparam logic [2:0] aru_bsub = 3'h4;
  localparam logic [2:0] aru_sub = 3'h5;
  localparam logic [2:0] aru_add = 3'h6;
  localparam logic [2:0] aru_badd = 3'h7;
  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [7:0] reg_instr = 8'h00;    // w: bits15:0 word1, 31:16 word2; issues
  localparam logic [7:0] reg_ctrl = 8'h04;     // mem placement, sxm, repeat count
  localparam logic [7:0] reg_ptr = 8'h08;      // dp, arp, temporary_operand_register
  localparam logic [7:0] reg_ar_base = 8'h10;  // ar0..ar7 at 0x10..0x2c
  localparam logic [7:0] reg_acc = 8'h30;
  localparam logic [7:0] reg_status = 8'h34;   // busy, global_interrupt_mask_bit, cycles
  localparam logic [7:0] reg_pc = 8'h38;       // pc / vector target, last operand address
  localparam logic [7:0] reg_data = 8'h3c;     // operand supplied by software
  localparam logic [15:0] vec_base = 16'h0000;
  localparam logic [15:0] vec_step = 16'h0002;
  localparam int unsigned software_interrupt_instr_cycles = 4;
  localparam int unsigned software_interrupt_instr_pwait = 3;
endpackage

// ---- hdl/acc_shifter.sv ----
// operand shifter and extension for accumulator loads
// assumes: combinational, same clock domain as its user
`timescale 1ns/1ps
`default_nettype none
module acc_shifter (
  // operand
  input wire logic [15:0] operand,
  input wire logic [4:0] amount,
  input wire logic sign_ext,
  // result
  output logic [31:0] result
);
  logic [31:0] ext;
  always_comb begin
    // upper bits follow the sign only when extension asked for
    ext = sign_ext ? {{16{operand[15]}}, operand} : {16'h0000, operand};
    result = ext << amount;  // low bits zero-filled
  end
endmodule
`default_nettype wire

// ---- hdl/aux_update.sv ----
// address update of the current auxiliary register for indirect operands
// assumes: pure combinational, driven from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module aux_update (
  // operands
  input wire logic [15:0] ar_cur,
  input wire logic [15:0] ar_idx,
  input wire logic [2:0] aux_update_code,
  // result
  output logic [15:0] ar_new
);
  // reverse-carry add: add with carry running toward the lsb
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  always_comb begin
    unique case (aux_update_code)
      acc_exec_pkg::aru_none: ar_new = ar_cur;
      acc_exec_pkg::aru_dec: ar_new = ar_cur - 16'h0001;
      acc_exec_pkg::aru_inc: ar_new = ar_cur + 16'h0001;
      acc_exec_pkg::aru_sub: ar_new = ar_cur - ar_idx;
      acc_exec_pkg::aru_add: ar_new = ar_cur + ar_idx;
      acc_exec_pkg::aru_badd: ar_new = rev16(rev16(ar_cur) + rev16(ar_idx));
      acc_exec_pkg::aru_bsub: ar_new = rev16(rev16(ar_cur) - rev16(ar_idx));
      // code 3 is not a legal update and leaves the register alone
      default: ar_new = ar_cur;
    endcase
  end
endmodule
`default_nettype wire

// ---- testbench/stack_model.sv ----
// behavioural hardware stack on the far side of the push port
// assumes: push_valid is a one-cycle pulse on mclk, push_data valid with it
`timescale 1ns/1ps
`default_nettype none
module stack_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // push side
  input wire logic push_valid,
  input wire logic [15:0] push_data,
  // observation
  output logic [7:0] depth_q,
  output logic [15:0] top_q
);
  // counts every sampled pulse, so a pulse held two cycles shows as two pushes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      depth_q <= 8'h00;
      top_q <= 16'h0000;
    end else if (push_valid) begin
      depth_q <= depth_q + 8'h01;
      top_q <= push_data;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/test_acc_exec.sv ----
// self-checking bench for acc_exec, driven over apb
// assumes: acc_exec_pkg, acc_exec and stack_model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_acc_exec;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, push_valid, busy;
  logic [7:0] paddr, depth;
  logic [31:0] pwdata, prdata;
  logic [15:0] push_data, top;
  int num_errors = 0;
  int cmp_count = 0;

  acc_exec u_acc_exec (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .push_valid(push_valid), .push_data(push_data), .busy(busy));
  stack_model u_stack_model (.mclk(mclk), .nrst(nrst), .push_valid(push_valid),
    .push_data(push_data), .depth_q(depth), .top_q(top));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----
  // shared tasks
  // ----
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("[FAIL] %0t %s never finished", $time, what);
    print_verdict();
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("apb");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic exec(input logic [31:0] ins);
    logic [31:0] s;
    int i;
    wr(acc_exec_pkg::reg_instr, ins);
    for (i = 0; i < 100; i++) begin
      rdv(acc_exec_pkg::reg_status, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 100) hang("instruction");
    chk({31'h0, busy}, 32'h0, "busy after");
  endtask

  // m: b0 ext operand, b1 ext code, b2 same block, b3 sign mode
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [3:0] d, input logic [3:0] p,
                                      input logic [7:0] n1);
    return {8'h00, n1, 4'h0, p, d, m};
  endfunction

  function automatic logic [31:0] sh(input logic [15:0] v, input logic [3:0] n, input logic s);
    logic [31:0] x;
    x = {(s ? {16{v[15]}} : 16'h0000), v};
    return x << n;
  endfunction

  function automatic logic [15:0] rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev[i] = v[15 - i];
  endfunction

  function automatic logic [15:0] upd(input logic [2:0] c, input logic [15:0] a, input logic [15:0] x);
    case (c)
      acc_exec_pkg::aru_dec: return a - 16'h0001;
      acc_exec_pkg::aru_inc: return a + 16'h0001;
      acc_exec_pkg::aru_sub: return a - x;
      acc_exec_pkg::aru_add: return a + x;
      acc_exec_pkg::aru_badd: return rev(rev(a) + rev(x));
      acc_exec_pkg::aru_bsub: return rev(rev(a) - rev(x));
      default: return a;
    endcase
  endfunction

  task automatic ld(input logic [31:0] ins, input logic [31:0] c, input logic [15:0] op,
                    input logic [31:0] ea, input logic [7:0] ec);
    logic [31:0] q;
    wr(acc_exec_pkg::reg_ctrl, c);
    wr(acc_exec_pkg::reg_data, {16'h0000, op});
    exec(ins);
    rdv(acc_exec_pkg::reg_acc, q);
    chk(q, ea, "acc");
    rdv(acc_exec_pkg::reg_status, q);
    chk({24'h0, q[15:8]}, {24'h0, ec}, "cycles");
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rdv(acc_exec_pkg::reg_status, q);
    chk({30'h0, q[1:0]}, 32'h2, "reset status");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped");
  endtask

  task automatic t_load_acc_shifted_instr;
    logic [31:0] q, w;
    wr(acc_exec_pkg::reg_ptr, {23'h0, 9'h1a5});
    for (int s = 0; s < 32; s++) begin
      w = {16'h0, acc_exec_pkg::op_load_acc_shifted_instr_sh, s[3:0], 8'h05};
      ld(w, ctl({s[4], 3'h0}, 4'h2, 4'h3, 8'h00), 16'h8001, sh(16'h8001, s[3:0], s[4]), 8'h01);
    end
    rdv(acc_exec_pkg::reg_pc, q);
    chk({16'h0, q[31:16]}, {16'h0, 9'h1a5, 7'h05}, "direct address");
    w = {16'h0, acc_exec_pkg::op_load_acc_shifted_instr_16, 8'h05};
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h00), 16'h8001, 32'h8001_0000, 8'h01);
    ld(w, ctl(4'h9, 4'h2, 4'h3, 8'h00), 16'h1234, 32'h1234_0000, 8'h03);
    ld(w, ctl(4'hb, 4'h2, 4'h3, 8'h00), 16'h1234, 32'h1234_0000, 8'h07);
    ld(w, ctl(4'hc, 4'h2, 4'h3, 8'h00), 16'h1234, 32'h1234_0000, 8'h02);
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h03), 16'h1234, 32'h1234_0000, 8'h04);
    ld(w, ctl(4'h9, 4'h2, 4'h3, 8'h03), 16'h1234, 32'h1234_0000, 8'h0c);
    ld(w, ctl(4'hb, 4'h2, 4'h3, 8'h03), 16'h1234, 32'h1234_0000, 8'h10);
  endtask

  // long form leaves the upper half set, so the low loads must clear it
  task automatic t_long_low;
    logic [31:0] w;
    w = {16'hf000, acc_exec_pkg::op_load_acc_shifted_instr_lk, 4'h4};
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h00), 16'h1234, 32'hffff_0000, 8'h02);
    ld(w, ctl(4'ha, 4'h2, 4'h3, 8'h00), 16'h1234, 32'hffff_0000, 8'h08);
    w = {16'h0, acc_exec_pkg::op_load_acc_low_instr, 8'h05};
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h00), 16'h8000, 32'h0000_8000, 8'h01);
    w = {16'h0, acc_exec_pkg::op_load_acc_low_instr_k, 8'hff};
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h00), 16'h8000, 32'h0000_00ff, 8'h01);
    ld(w, ctl(4'ha, 4'h2, 4'h3, 8'h00), 16'h8000, 32'h0000_00ff, 8'h04);
  endtask

  task automatic t_load_acc_temporary_operand_register_shift_instr;
    logic [31:0] w;
    w = {16'h0, acc_exec_pkg::op_load_acc_temporary_operand_register_shift_instr, 8'h01};
    wr(acc_exec_pkg::reg_ptr, {16'h0011, 16'h0000});
    ld(w, ctl(4'h8, 4'h2, 4'h3, 8'h00), 16'hff00, 32'hffff_fe00, 8'h01);
    wr(acc_exec_pkg::reg_ptr, {16'h0024, 16'h0000});
    ld(w, ctl(4'h1, 4'h2, 4'h3, 8'h00), 16'h1376, 32'h0001_3760, 8'h03);
    ld(w, ctl(4'hb, 4'h2, 4'h3, 8'h00), 16'h8000, 32'hfff8_0000, 8'h07);
  endtask

  task automatic t_ind;
    logic [2:0] c [7];
    logic [31:0] q;
    c = '{acc_exec_pkg::aru_none, acc_exec_pkg::aru_dec, acc_exec_pkg::aru_inc, acc_exec_pkg::aru_bsub,
          acc_exec_pkg::aru_sub, acc_exec_pkg::aru_add, acc_exec_pkg::aru_badd};
    for (int j = 0; j < 7; j++) begin
      wr(acc_exec_pkg::reg_ptr, {20'h0, 3'h1, 9'h0});
      wr(acc_exec_pkg::reg_ar_base, 32'h0000_0002);
      wr(acc_exec_pkg::reg_ar_base + 8'h04, 32'h0000_0310);
      ld({16'h0, acc_exec_pkg::op_load_acc_shifted_instr_16, 1'b1, c[j], 4'hb}, 32'h0, 16'h7abc, 32'h7abc_0000, 8'h01);
      rdv(acc_exec_pkg::reg_ar_base + 8'h04, q);
      chk({16'h0, q[15:0]}, {16'h0, upd(c[j], 16'h0310, 16'h0002)}, "aux update");
      rdv(acc_exec_pkg::reg_ptr, q);
      chk({29'h0, q[11:9]}, 32'h3, "next pointer");
      rdv(acc_exec_pkg::reg_pc, q);
      chk({16'h0, q[31:16]}, 32'h0310, "indirect address");
    end
  endtask

  // reset leaves the mask set, so the jump also shows it ignores the mask
  task automatic t_software_interrupt_instr;
    logic [31:0] q;
    logic [7:0] d0;
    logic [4:0] k;
    for (int j = 0; j < 2; j++) begin
      k = j[0] ? 5'h1f : 5'h00;
      wr(acc_exec_pkg::reg_pc, 32'h0000_0100);
      d0 = depth;
      exec({16'h0, acc_exec_pkg::op_software_interrupt_instr, k});
      chk({24'h0, depth}, {24'h0, d0 + 8'h01}, "push count");
      chk({16'h0, top}, 32'h0000_0101, "pushed pc");
      rdv(acc_exec_pkg::reg_pc, q);
      chk({16'h0, q[15:0]}, {16'h0, acc_exec_pkg::vec_base + acc_exec_pkg::vec_step * {11'h0, k}}, "vector");
      rdv(acc_exec_pkg::reg_status, q);
      chk({30'h0, q[1:0]}, 32'h2, "mask after");
    end
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_load_acc_shifted_instr();
    t_long_low();
    t_load_acc_temporary_operand_register_shift_instr();
    t_ind();
    t_software_interrupt_instr();
    print_verdict();
  end
endmodule
`default_nettype wire
